// file: rtl/hub_id_map.svh
`ifndef HUB_ID_MAP_SVH
`define HUB_ID_MAP_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define HUB_OFS_MAKER_CODE_LOW  8'h01
`define HUB_OFS_MAKER_CODE_HIGH 8'h02
`define HUB_OFS_PART_CODE_LOW   8'h03
`define HUB_OFS_PART_CODE_HIGH  8'h04
`define HUB_OFS_DEVICE_CONFIG   8'h05

// ----------------------------------------------------------------------
// device configuration fields
// ----------------------------------------------------------------------
`define HUB_CFG_RESET           8'h10
`define HUB_CFG_RSVD_ONE        8'h10
`define HUB_CFG_WRITE_MASK      8'hef
`define HUB_CFG_GANGED_BIT      3
`define HUB_CFG_POWER_MODE_BIT  2

// ----------------------------------------------------------------------
// descriptor and misc values
// ----------------------------------------------------------------------
`define HUB_HS_PART_LOW_XOR     8'h02
`define HUB_UNMAPPED_READ       8'h00
`define HUB_STRAP_RESET         2'h0

`endif

// file: rtl/hub_id_pkg.sv
`default_nettype none

package hub_id_pkg;

	// configuration access mode, decoded from the cfg_mode input every cycle
	typedef enum logic [1:0] {
		mode_none   = 2'b00,
		mode_eeprom = 2'b01,
		mode_smbus  = 2'b10,
		mode_spare  = 2'b11
	} cfg_mode_t;

	// state of the strap sampler
	typedef struct packed {
		logic       done;
		logic       pulse;
		logic [1:0] straps;
	} strap_state_t;

	// state of the register bank
	typedef struct packed {
		logic [7:0]  maker_code_low;
		logic [7:0]  maker_code_high;
		logic [7:0]  part_code_low;
		logic [7:0]  part_code_high;
		logic [7:0]  dev_cfg;
		logic [7:0]  rdata;
		logic        rd_valid;
		logic        wr_refused;
		logic        id_from_otp;
		logic [15:0] desc_maker;
		logic [15:0] desc_ss_part;
		logic [15:0] desc_hs_part;
	} bank_state_t;

endpackage

`default_nettype wire

// file: rtl/strap_sampler.sv
`default_nettype none
`include "hub_id_map.svh"

module strap_sampler (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       arst_n,
	// strap pins
	input  wire logic [1:0] strap_in,
	// captured value
	output logic       [1:0] strap_value,
	output logic             strap_pulse
);

	hub_id_pkg::strap_state_t cur;
	hub_id_pkg::strap_state_t next_cur;

	// ------------------------------------------------------------------
	// capture once, on the first edge after reset release
	// ------------------------------------------------------------------
	always_comb begin
		next_cur       = cur;
		next_cur.pulse = 1'b0;
		if (!cur.done) begin
			next_cur.done   = 1'b1;
			next_cur.pulse  = 1'b1;
			next_cur.straps = strap_in;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cur <= '{done: 1'b0, pulse: 1'b0, straps: `HUB_STRAP_RESET};
		end else begin
			cur <= next_cur;
		end
	end

	assign strap_value = cur.straps;
	assign strap_pulse = cur.pulse;

endmodule

`default_nettype wire

// file: rtl/hub_identity_config_regs.sv
// Notes on behaviour
// - maker code bytes may be rewritten with a customer value.
// - part code bytes may be rewritten with a customer value.
// - identifier bytes writable only unless both fused identifiers are non-zero.
// - with both fused identifiers non-zero, reads return the fused values.
// - superspeed descriptor reports the part code low byte unchanged.
// - usb 2.0 descriptor reports part code low byte with bit 1 inverted.
// - configuration byte resets with bit 4 one, bits 7:5 and 1:0 zero.
// - ganged bit sampled from its strap pin when reset is released.
// - writes only in eeprom-load or smbus mode, byte-wide accesses.
`default_nettype none
`include "hub_id_map.svh"

module hub_identity_config_regs #(
	// factory defaults; values are arbitrary
	parameter logic [7:0] default_maker_code_low  = 8'ha5,
	parameter logic [7:0] default_maker_code_high = 8'h3c,
	parameter logic [7:0] default_part_code_low   = 8'h6e,
	parameter logic [7:0] default_part_code_high  = 8'h2b
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        arst_n,
	// strap pins
	input  wire logic        strap_ganged,
	input  wire logic        strap_power_mode,
	// configuration mode
	input  wire logic [1:0]  cfg_mode,
	// fused identifiers
	input  wire logic [15:0] otp_maker_code,
	input  wire logic [15:0] otp_part_code,
	// byte access port
	input  wire logic        cfg_wr_en,
	input  wire logic        cfg_rd_en,
	input  wire logic [7:0]  cfg_addr,
	input  wire logic [7:0]  cfg_wdata,
	output logic      [7:0]  cfg_rdata,
	output logic             cfg_rd_valid,
	output logic             cfg_wr_refused,
	// descriptor values
	output logic      [15:0] desc_maker_code,
	output logic      [15:0] desc_ss_part_code,
	output logic      [15:0] desc_hs_part_code,
	output logic             id_from_otp,
	// configuration byte
	output logic      [7:0]  device_config
);

	hub_id_pkg::bank_state_t cur;
	hub_id_pkg::bank_state_t next_cur;

	logic [1:0]  strap_value;
	logic        strap_pulse;
	logic        otp_lock;
	logic        write_window;
	logic        id_addr;
	logic        addr_mapped;
	logic        wr_block;
	logic [15:0] eff_maker;
	logic [15:0] eff_part;

	// ------------------------------------------------------------------
	// strap sampling
	// ------------------------------------------------------------------
	strap_sampler strap_sampler_inst (
		.clk         (clk),
		.arst_n      (arst_n),
		.strap_in    ({strap_ganged, strap_power_mode}),
		.strap_value (strap_value),
		.strap_pulse (strap_pulse)
	);

	// ------------------------------------------------------------------
	// lock and window decode
	// ------------------------------------------------------------------
	// any bit set in each of both identifiers
	assign otp_lock = (|otp_maker_code) && (|otp_part_code);

	assign write_window =
		(hub_id_pkg::cfg_mode_t'(cfg_mode) == hub_id_pkg::mode_eeprom) ||
		(hub_id_pkg::cfg_mode_t'(cfg_mode) == hub_id_pkg::mode_smbus);

	// ------------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------------
	always_comb begin
		id_addr     = 1'b0;
		addr_mapped = 1'b0;
		if (cfg_addr == `HUB_OFS_MAKER_CODE_LOW) begin
			id_addr     = 1'b1;
			addr_mapped = 1'b1;
		end else if (cfg_addr == `HUB_OFS_MAKER_CODE_HIGH) begin
			id_addr     = 1'b1;
			addr_mapped = 1'b1;
		end else if (cfg_addr == `HUB_OFS_PART_CODE_LOW) begin
			id_addr     = 1'b1;
			addr_mapped = 1'b1;
		end else if (cfg_addr == `HUB_OFS_PART_CODE_HIGH) begin
			id_addr     = 1'b1;
			addr_mapped = 1'b1;
		end else if (cfg_addr == `HUB_OFS_DEVICE_CONFIG) begin
			addr_mapped = 1'b1;
		end else begin
			id_addr     = 1'b0;
			addr_mapped = 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// write gate
	// ------------------------------------------------------------------
	// refused writes
	assign wr_block = !write_window || !addr_mapped ||
		(id_addr && otp_lock);

	assign eff_maker = otp_lock ? otp_maker_code :
		{cur.maker_code_high, cur.maker_code_low};
	assign eff_part = otp_lock ? otp_part_code :
		{cur.part_code_high, cur.part_code_low};

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	always_comb begin
		next_cur            = cur;
		next_cur.rd_valid   = 1'b0;
		next_cur.wr_refused = 1'b0;
		next_cur.id_from_otp = otp_lock;

		if (strap_pulse) begin
			next_cur.dev_cfg[`HUB_CFG_GANGED_BIT]     = strap_value[1];
			next_cur.dev_cfg[`HUB_CFG_POWER_MODE_BIT] = strap_value[0];
		end

		if (cfg_wr_en) begin
			if (wr_block) begin
				next_cur.wr_refused = 1'b1;
			end else if (cfg_addr == `HUB_OFS_MAKER_CODE_LOW) begin
				next_cur.maker_code_low = cfg_wdata;
			end else if (cfg_addr == `HUB_OFS_MAKER_CODE_HIGH) begin
				next_cur.maker_code_high = cfg_wdata;
			end else if (cfg_addr == `HUB_OFS_PART_CODE_LOW) begin
				next_cur.part_code_low = cfg_wdata;
			end else if (cfg_addr == `HUB_OFS_PART_CODE_HIGH) begin
				next_cur.part_code_high = cfg_wdata;
			end else if (cfg_addr == `HUB_OFS_DEVICE_CONFIG) begin
				next_cur.dev_cfg = (cfg_wdata & `HUB_CFG_WRITE_MASK) |
					`HUB_CFG_RSVD_ONE;
			end
		end

		if (cfg_rd_en) begin
			next_cur.rd_valid = 1'b1;
			if (cfg_addr == `HUB_OFS_MAKER_CODE_LOW) begin
				next_cur.rdata = eff_maker[7:0];
			end else if (cfg_addr == `HUB_OFS_MAKER_CODE_HIGH) begin
				next_cur.rdata = eff_maker[15:8];
			end else if (cfg_addr == `HUB_OFS_PART_CODE_LOW) begin
				next_cur.rdata = eff_part[7:0];
			end else if (cfg_addr == `HUB_OFS_PART_CODE_HIGH) begin
				next_cur.rdata = eff_part[15:8];
			end else if (cfg_addr == `HUB_OFS_DEVICE_CONFIG) begin
				next_cur.rdata = cur.dev_cfg;
			end else begin
				next_cur.rdata = `HUB_UNMAPPED_READ;
			end
		end

		next_cur.desc_maker = eff_maker;
		next_cur.desc_ss_part = eff_part;
		next_cur.desc_hs_part = {eff_part[15:8],
			eff_part[7:0] ^ `HUB_HS_PART_LOW_XOR};
	end

	// ------------------------------------------------------------------
	// state register
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cur.maker_code_low  <= default_maker_code_low;
			cur.maker_code_high <= default_maker_code_high;
			cur.part_code_low   <= default_part_code_low;
			cur.part_code_high  <= default_part_code_high;
			cur.dev_cfg         <= `HUB_CFG_RESET;
			cur.rdata           <= `HUB_UNMAPPED_READ;
			cur.rd_valid        <= 1'b0;
			cur.wr_refused      <= 1'b0;
			cur.id_from_otp     <= 1'b0;
			cur.desc_maker      <= {default_maker_code_high,
				default_maker_code_low};
			cur.desc_ss_part    <= {default_part_code_high,
				default_part_code_low};
			cur.desc_hs_part    <= {default_part_code_high,
				default_part_code_low ^ `HUB_HS_PART_LOW_XOR};
		end else begin
			cur <= next_cur;
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	assign cfg_rdata         = cur.rdata;
	assign cfg_rd_valid      = cur.rd_valid;
	assign cfg_wr_refused    = cur.wr_refused;
	assign desc_maker_code   = cur.desc_maker;
	assign desc_ss_part_code = cur.desc_ss_part;
	assign desc_hs_part_code = cur.desc_hs_part;
	assign id_from_otp       = cur.id_from_otp;
	assign device_config     = cur.dev_cfg;

endmodule

`default_nettype wire

// file: bench/hub_regs_sva.sv
`default_nettype none
module hub_regs_sva (
	// clock and reset
	input wire logic        clk,
	input wire logic        arst_n,
	// block inputs
	input wire logic        strap_ganged,
	input wire logic [1:0]  cfg_mode,
	input wire logic [15:0] otp_maker_code,
	input wire logic [15:0] otp_part_code,
	input wire logic        cfg_wr_en,
	input wire logic        cfg_rd_en,
	input wire logic [7:0]  cfg_addr,
	// block outputs
	input wire logic [7:0]  cfg_rdata,
	input wire logic        cfg_rd_valid,
	input wire logic        cfg_wr_refused,
	input wire logic [15:0] desc_ss_part_code,
	input wire logic [15:0] desc_hs_part_code,
	input wire logic        id_from_otp,
	input wire logic [7:0]  device_config
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	logic lock;
	assign lock = |otp_maker_code && |otp_part_code;
	a_mode_refuse: assert property (cfg_wr_en && cfg_mode[0] == cfg_mode[1]
		|=> cfg_wr_refused) else $error("write outside load modes taken");
	a_lock_refuse: assert property (cfg_wr_en && lock && cfg_addr > 8'h00
		&& cfg_addr < 8'h05 |=> cfg_wr_refused) else $error("locked id written");
	a_lock_flag: assert property ($past(arst_n)
		|-> id_from_otp == $past(lock)) else $error("lock flag wrong");
	a_hs_xor: assert property (desc_hs_part_code
		== (desc_ss_part_code ^ 16'h0002)) else $error("hs part code wrong");
	a_otp_read: assert property (cfg_rd_en && lock && cfg_addr == 8'h01
		|=> cfg_rdata == $past(otp_maker_code[7:0])) else $error("otp read");
	a_bit4_one: assert property (device_config[4])
		else $error("config bit 4 low");
	a_strap_load: assert property ($rose(arst_n)
		|-> ##2 device_config[3] == strap_ganged) else $error("strap lost");
	a_read_pulse: assert property ($past(arst_n)
		|-> cfg_rd_valid == $past(cfg_rd_en)) else $error("read pulse wrong");
	cover property (id_from_otp);
	cover property (cfg_wr_refused);
	cover property (cfg_rd_valid);
endmodule
bind hub_identity_config_regs hub_regs_sva hub_regs_sva_inst (.clk, .arst_n,
	.strap_ganged, .cfg_mode, .otp_maker_code, .otp_part_code, .cfg_wr_en,
	.cfg_rd_en, .cfg_addr, .cfg_rdata, .cfg_rd_valid, .cfg_wr_refused,
	.desc_ss_part_code, .desc_hs_part_code, .id_from_otp, .device_config);
`default_nettype wire

// file: bench/cfg_host_model.sv
`default_nettype none
module cfg_host_model (
	// clock
	input  wire logic       clk,
	// answers from the block
	input  wire logic [7:0] rdata,
	input  wire logic       refused,
	// byte request
	output logic            wr_en = 1'b0,
	output logic            rd_en = 1'b0,
	output logic      [7:0] addr = 8'h00,
	output logic      [7:0] wdata = 8'h00
);
	timeunit 1ns;
	timeprecision 1ns;
	task automatic xfer(input logic w, input logic [7:0] a, d,
		output logic [7:0] q, output logic r);
		@(posedge clk);
		wr_en <= w;
		rd_en <= !w;
		addr  <= a;
		wdata <= d;
		@(posedge clk);
		wr_en <= 1'b0;
		rd_en <= 1'b0;
		addr  <= ~a;
		wdata <= ~d;
		#1;
		q = rdata;
		r = refused;
	endtask
endmodule
`default_nettype wire

// file: bench/hub_identity_config_regs_test.sv
`default_nettype none
module hub_identity_config_regs_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'b0, arst_n = 1'b0;
	logic        strap_ganged = 1'b1, strap_power_mode = 1'b0;
	logic [1:0]  cfg_mode = 2'h1;
	logic [15:0] otp_maker_code = 16'h0000, otp_part_code = 16'h0000;
	logic        cfg_wr_en, cfg_rd_en, cfg_rd_valid, cfg_wr_refused, r;
	logic [7:0]  cfg_addr, cfg_wdata, cfg_rdata, device_config, q;
	logic [15:0] desc_maker_code, desc_ss_part_code, desc_hs_part_code;
	logic        id_from_otp;
	int          errors = 0, check_count = 0;
	always #50 clk = ~clk;
	hub_identity_config_regs hub_identity_config_regs_inst (.clk, .arst_n,
		.strap_ganged, .strap_power_mode, .cfg_mode, .otp_maker_code,
		.otp_part_code, .cfg_wr_en, .cfg_rd_en, .cfg_addr, .cfg_wdata,
		.cfg_rdata, .cfg_rd_valid, .cfg_wr_refused, .desc_maker_code,
		.desc_ss_part_code, .desc_hs_part_code, .id_from_otp,
		.device_config);
	cfg_host_model cfg_host_model_inst (.clk, .rdata(cfg_rdata),
		.refused(cfg_wr_refused), .wr_en(cfg_wr_en), .rd_en(cfg_rd_en),
		.addr(cfg_addr), .wdata(cfg_wdata));
	// ----
	// checking helpers
	// ----
	task automatic chk(string n, logic [15:0] s, e);
		check_count++;
		if (s !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic rd(logic [7:0] a, e);
		cfg_host_model_inst.xfer(1'b0, a, 8'h00, q, r);
		chk("cfg_rdata", {8'h00, q}, {8'h00, e});
		chk("cfg_rd_valid", {15'h0, cfg_rd_valid}, 16'h0001);
	endtask
	task automatic wr(logic [7:0] a, d, logic e);
		cfg_host_model_inst.xfer(1'b1, a, d, q, r);
		chk("cfg_wr_refused", {15'h0, r}, {15'h0, e});
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ----
	// scenarios
	// ----
	task automatic t_defaults();
		rd(8'h01, 8'ha5);
		rd(8'h03, 8'h6e);
		rd(8'h05, 8'h18);
		chk("device_config", {8'h00, device_config}, 16'h0018);
		chk("ss", desc_ss_part_code, 16'h2b6e);
		chk("hs", desc_hs_part_code, 16'h2b6c);
		$display("defaults done");
	endtask
	task automatic t_modes();
		for (int m = 0; m < 4; m++) begin
			@(posedge clk) cfg_mode <= 2'(m);
			wr(8'h01, 8'(8'h11 + m), m == 0 || m == 3);
		end
		@(posedge clk) cfg_mode <= 2'h1;
		rd(8'h01, 8'h13);
		$display("modes done");
	endtask
	task automatic t_ids();
		wr(8'h02, 8'hc4, 1'b0);
		wr(8'h03, 8'h9a, 1'b0);
		wr(8'h04, 8'h77, 1'b0);
		rd(8'h04, 8'h77);
		chk("maker", desc_maker_code, 16'hc413);
		chk("ss", desc_ss_part_code, 16'h779a);
		chk("hs", desc_hs_part_code, 16'h7798);
		wr(8'h05, 8'h00, 1'b0);
		rd(8'h05, 8'h10);
		chk("device_config", {8'h00, device_config}, 16'h0010);
		$display("ids done");
	endtask
	task automatic t_lock();
		@(posedge clk) otp_maker_code <= 16'h1234;
		wr(8'h01, 8'h55, 1'b0);
		@(posedge clk) otp_part_code <= 16'h0080;
		wr(8'h01, 8'h66, 1'b1);
		rd(8'h01, 8'h34);
		rd(8'h04, 8'h00);
		chk("lock", {15'h0, id_from_otp}, 16'h0001);
		chk("maker", desc_maker_code, 16'h1234);
		@(posedge clk) otp_part_code <= 16'h0000;
		rd(8'h01, 8'h55);
		chk("lock", {15'h0, id_from_otp}, 16'h0000);
		rd(8'h06, 8'h00);
		wr(8'h06, 8'hff, 1'b1);
		$display("lock done");
	endtask
	task automatic t_reset();
		@(posedge clk) begin
			arst_n           <= 1'b0;
			strap_ganged     <= 1'b0;
			strap_power_mode <= 1'b1;
		end
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		repeat (2) @(posedge clk);
		rd(8'h05, 8'h14);
		chk("device_config", {8'h00, device_config}, 16'h0014);
		rd(8'h02, 8'h3c);
		rd(8'h04, 8'h2b);
		$display("reset done");
	endtask
	initial begin
		repeat (12) @(posedge clk);
		arst_n <= 1'b1;
		repeat (2) @(posedge clk);
		t_defaults();
		t_modes();
		t_ids();
		t_lock();
		t_reset();
		end_of_test();
	end
	initial begin
		#200000;
		errors++;
		end_of_test();
	end
endmodule
`default_nettype wire
